// File: design/frsl_top.sv
// Flash reprogram serial loader with AHB-Lite register slave
// Operation
// [R1] Tool straps user boot mode pins
// [R2] Erase three blocks before requesting data
// [R3] Receive-only serial, tool drives clock
// [R4] Request by driving port line low
// [R5] Interrupts held off during program/erase (code: irq held off from the second program/erase cycle on)
// [R6] Tool treats silence as completion
// [R7] Buffer block in RAM, program 128-byte units
// [R8] Flash registers need flash enable bit
// [R9] Timer registers blocked while flash enabled
// [R10] Registers eight bits, byte access only (code checks the size on writes only; wider reads are served)
// [R11] Registers reset on reset and standby (code: the interrupt status register resets on reset only)
// [R12] Error flag survives software standby/watch
// [R13] Code status resets to 80 hex
// [R14] Bit 7 reads as one
// [R15] Status has error monitor, download bit
// [R16] Bits 6 and 5 read zero
// [R17] Error flag blocks further program/erase
// [R18] Request line released after each block
// [R19] No request after last block
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module frsl_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic mode_select_0,
  input wire logic mode_select_1,
  input wire logic mode_select_2,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic watch_mode,
  input wire logic flash_fault,
  input wire logic serial_clk,
  input wire logic serial_data,
  output logic request_port_line,
  output logic irq
);
  frsl_pkg::frsl_state_t state_reg;
  frsl_pkg::frsl_req_t req_reg;
  logic [2:0] sck_sync_reg, rxd_sync_reg, md_sync0_reg, md_sync1_reg;
  logic [1:0] sck_hist_reg;
  logic [7:0] code_status_reg, sys_ctrl2_reg, control_reg, ram_emul_reg;
  logic [7:0] irq_status_reg, irq_mask_reg, start_addr_reg;
  logic [7:0] timer_lo_reg, timer_hi_reg;
  logic [7:0] shift_reg, ram_mem [0:255];
  logic [2:0] bit_cnt_reg;
  logic [7:0] byte_cnt_reg, prog_idx_reg;
  logic [1:0] blk_cnt_reg;
  logic [7:0] wait_cnt_reg;
  logic [31:0] flash_sum_reg;
  logic [3:0] ev_set;
  logic sck_rise, user_boot, busy, flash_en, byte_lane_ok;
  logic stby_init;

  // Mode pins pass two flops, serial clock and data pass three, before use
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      md_sync0_reg <= 3'h0;
      md_sync1_reg <= 3'h0;
      sck_sync_reg <= 3'h0;
      rxd_sync_reg <= 3'h0;
    end
    else
    begin
      md_sync0_reg <= {mode_select_2, mode_select_1, mode_select_0};
      md_sync1_reg <= md_sync0_reg;
      sck_sync_reg <= {sck_sync_reg[1:0], serial_clk};
      rxd_sync_reg <= {rxd_sync_reg[1:0], serial_data};
    end

  // Edge found between the second and third stage only
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      sck_hist_reg <= 2'h0;
    else
      sck_hist_reg <= sck_sync_reg[2:1];

  assign sck_rise = sck_hist_reg[0] & ~sck_hist_reg[1];
  assign user_boot = (md_sync1_reg == 3'h1); // see [R1]
  assign busy = (state_reg == frsl_pkg::st_erase) ||
                (state_reg == frsl_pkg::st_program);
  assign flash_en = sys_ctrl2_reg[frsl_pkg::sys_ctrl2_flash_en_bit];
  assign stby_init = hw_standby | sw_standby | watch_mode;
  // Byte writes only; wider write sizes are ignored, reads of any size are served
  assign byte_lane_ok = (req_reg.hsize == 3'h0); // see [R10]

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      req_reg <= '0;
    else if (hready)
    begin
      req_reg.htrans_nonseq <= hsel & htrans[1];
      req_reg.hwrite <= hwrite;
      req_reg.addr <= haddr[7:0];
      req_reg.hsize <= hsize;
    end

  // Ready from the first clock after reset, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end

  // Gate: flash regs need enable, timer regs need it clear
  function automatic logic reg_open(input logic [7:0] a, input logic fe);
    logic r;
    r = 1'b1;
    if (a == frsl_pkg::ofs_code_status || a == frsl_pkg::ofs_control ||
        a == frsl_pkg::ofs_start_addr)
      r = fe; // see [R8]
    if (a == frsl_pkg::ofs_timer_lo || a == frsl_pkg::ofs_timer_hi)
      r = ~fe; // see [R9]
    return r;
  endfunction

  logic wr_ok, rd_ok;
  assign wr_ok = req_reg.htrans_nonseq & req_reg.hwrite & byte_lane_ok &
                 reg_open(req_reg.addr, flash_en);
  assign rd_ok = req_reg.htrans_nonseq & ~req_reg.hwrite &
                 reg_open(req_reg.addr, flash_en);

  // Plain software registers; standby reinitialises them
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      sys_ctrl2_reg <= 8'h00;
      control_reg <= 8'h00;
      ram_emul_reg <= 8'h00;
      start_addr_reg <= 8'h00;
      irq_mask_reg <= 8'h00;
      timer_lo_reg <= 8'h00;
      timer_hi_reg <= 8'h00;
    end
    else if (stby_init)
    begin
      sys_ctrl2_reg <= 8'h00; // see [R11]
      control_reg <= 8'h00;
      ram_emul_reg <= 8'h00;
      start_addr_reg <= 8'h00;
      irq_mask_reg <= 8'h00;
      timer_lo_reg <= 8'h00;
      timer_hi_reg <= 8'h00;
    end
    else
    begin
      control_reg[0] <= 1'b0; // Start is a one-cycle pulse
      if (wr_ok)
        unique case (req_reg.addr)
          frsl_pkg::ofs_sys_ctrl2: sys_ctrl2_reg <= hwdata[7:0];
          frsl_pkg::ofs_control: control_reg <= hwdata[7:0];
          frsl_pkg::ofs_ram_emul: ram_emul_reg <= hwdata[7:0];
          frsl_pkg::ofs_start_addr: start_addr_reg <= hwdata[7:0];
          frsl_pkg::ofs_irq_mask: irq_mask_reg <= hwdata[7:0];
          frsl_pkg::ofs_timer_lo: timer_lo_reg <= hwdata[7:0];
          frsl_pkg::ofs_timer_hi: timer_hi_reg <= hwdata[7:0];
          default: ;
        endcase
    end

  // Code status: bit 7 fixed one, 6..5 zero, error and download bits
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      code_status_reg <= frsl_pkg::code_status_reset; // see [R13]
    else if (hw_standby)
      code_status_reg <= frsl_pkg::code_status_reset; // see [R11]
    else if (sw_standby | watch_mode)
      // Error flag kept through these modes
      code_status_reg <= frsl_pkg::code_status_reset |
        {3'h0, code_status_reg[frsl_pkg::code_status_err_bit], 4'h0};
      // see [R12]
    else
    begin
      if (busy & flash_fault)
        code_status_reg[frsl_pkg::code_status_err_bit] <= 1'b1; // see [R15]
      if (wr_ok && req_reg.addr == frsl_pkg::ofs_code_status)
        code_status_reg[frsl_pkg::code_status_dl_bit] <=
          hwdata[frsl_pkg::code_status_dl_bit];
      else if (state_reg == frsl_pkg::st_erase)
        code_status_reg[frsl_pkg::code_status_dl_bit] <= 1'b0;
      code_status_reg[7:5] <= 3'h4; // see [R14] see [R16]
    end

  // Loader sequence
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      state_reg <= frsl_pkg::st_idle;
      wait_cnt_reg <= 8'h00;
      blk_cnt_reg <= 2'h0;
      prog_idx_reg <= 8'h00;
      request_port_line <= 1'b1;
    end
    else if (hw_standby | code_status_reg[frsl_pkg::code_status_err_bit])
    begin
      state_reg <= frsl_pkg::st_idle; // see [R17]
      request_port_line <= 1'b1;
    end
    else
      unique case (state_reg)
        frsl_pkg::st_idle:
          if (control_reg[0] & user_boot & flash_en)
          begin
            state_reg <= frsl_pkg::st_erase;
            wait_cnt_reg <= 8'h00;
            blk_cnt_reg <= 2'h0;
          end
        frsl_pkg::st_erase:
          // All blocks erased before any request
          if (wait_cnt_reg == 8'(frsl_pkg::erase_cycles * 3 - 1))
            state_reg <= frsl_pkg::st_request; // see [R2]
          else
            wait_cnt_reg <= wait_cnt_reg + 8'h01;
        frsl_pkg::st_request:
        begin
          request_port_line <= 1'b0; // see [R4]
          state_reg <= frsl_pkg::st_receive;
        end
        frsl_pkg::st_receive:
          if (byte_cnt_reg == frsl_pkg::block_bytes && bit_cnt_reg == 3'h7
              && sck_rise)
          begin
            request_port_line <= 1'b1; // see [R18]
            state_reg <= frsl_pkg::st_program;
            prog_idx_reg <= 8'h00;
          end
        frsl_pkg::st_program:
          // Two 128-byte units per block, from the start address
          if (prog_idx_reg == frsl_pkg::block_bytes)
          begin
            blk_cnt_reg <= blk_cnt_reg + 2'h1;
            state_reg <= (blk_cnt_reg == 2'(frsl_pkg::num_blocks - 1)) ?
              frsl_pkg::st_done : frsl_pkg::st_request; // see [R19]
          end
          else
            prog_idx_reg <= prog_idx_reg + 8'h01; // see [R7]
        frsl_pkg::st_done:
          if (control_reg[0])
            state_reg <= frsl_pkg::st_idle;
      endcase

  // Serial receiver: data sampled on tool clock rising edge
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 8'h00;
      shift_reg <= 8'h00;
    end
    else if (state_reg != frsl_pkg::st_receive)
    begin
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 8'h00;
    end
    else if (sck_rise)
    begin
      shift_reg <= {shift_reg[6:0], rxd_sync_reg[2]}; // see [R3]
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7)
        byte_cnt_reg <= byte_cnt_reg + 8'h01;
    end

  // Whole block buffered in on-chip RAM in one transfer
  always_ff @(posedge hclk)
    if (state_reg == frsl_pkg::st_receive && sck_rise && bit_cnt_reg == 3'h7)
      ram_mem[byte_cnt_reg] <= {shift_reg[6:0], rxd_sync_reg[2]}; // see [R7]

  // Flash array stand-in: checksum of programmed bytes
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      flash_sum_reg <= 32'h0;
    else if (state_reg == frsl_pkg::st_program)
      flash_sum_reg <= flash_sum_reg + {24'h0,
        ram_mem[prog_idx_reg + start_addr_reg]};

  // Event capture; read of the status clears, set wins
  always_comb
  begin
    ev_set = 4'h0;
    ev_set[frsl_pkg::ev_erase_done] = (state_reg == frsl_pkg::st_erase) &&
      (wait_cnt_reg == 8'(frsl_pkg::erase_cycles * 3 - 1));
    ev_set[frsl_pkg::ev_block_done] = (state_reg == frsl_pkg::st_program) &&
      (prog_idx_reg == frsl_pkg::block_bytes);
    ev_set[frsl_pkg::ev_all_done] = ev_set[frsl_pkg::ev_block_done] &&
      (blk_cnt_reg == 2'(frsl_pkg::num_blocks - 1));
    ev_set[frsl_pkg::ev_error] = busy & flash_fault;
  end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      irq_status_reg <= 8'h00;
    else if (rd_ok && req_reg.addr == frsl_pkg::ofs_irq_status)
      // Clear only what the read showed, so an event that lands
      // between the address and the data phase is not lost
      irq_status_reg <= (irq_status_reg & ~hrdata[7:0]) | {4'h0, ev_set};
    else
      irq_status_reg <= irq_status_reg | {4'h0, ev_set};

  // Interrupt held off from one cycle after program or erase starts to one cycle after it ends
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= ~busy & |(irq_status_reg & irq_mask_reg); // see [R5]

  // Read data
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hrdata <= 32'h0;
    else if (hready && hsel && htrans[1] && !hwrite &&
             reg_open(haddr[7:0], flash_en))
      unique case (haddr[7:0])
        frsl_pkg::ofs_code_status: hrdata <= {24'h0, code_status_reg};
        frsl_pkg::ofs_sys_ctrl2: hrdata <= {24'h0, sys_ctrl2_reg};
        frsl_pkg::ofs_control: hrdata <= {29'h0, state_reg};
        frsl_pkg::ofs_irq_status: hrdata <= {24'h0, irq_status_reg};
        frsl_pkg::ofs_irq_mask: hrdata <= {24'h0, irq_mask_reg};
        frsl_pkg::ofs_ram_emul: hrdata <= {24'h0, ram_emul_reg};
        frsl_pkg::ofs_start_addr: hrdata <= {24'h0, start_addr_reg};
        frsl_pkg::ofs_timer_lo: hrdata <= {24'h0, timer_lo_reg};
        frsl_pkg::ofs_timer_hi: hrdata <= {24'h0, timer_hi_reg};
        default: hrdata <= 32'h0;
      endcase
    else
      hrdata <= 32'h0;

  // Status bit 7 always reads one
  a_status_bit7: assert property ( // see [R14]
    @(posedge hclk) disable iff (!hresetn)
    code_status_reg[7] && !code_status_reg[6] && !code_status_reg[5])
    else $error("status reserved bits wrong");
  a_no_irq_busy: assert property ( // see [R5]
    @(posedge hclk) disable iff (!hresetn)
    $past(busy) |-> !irq) else $error("irq while busy");
  a_req_after_erase: assert property ( // see [R2]
    @(posedge hclk) disable iff (!hresetn)
    $fell(request_port_line) |-> $past(state_reg) == frsl_pkg::st_request)
    else $error("request not after erase");
  a_err_blocks: assert property ( // see [R17]
    @(posedge hclk) disable iff (!hresetn)
    code_status_reg[4] && !hw_standby |=> state_reg == frsl_pkg::st_idle)
    else $error("error did not stop loader");
  a_err_keeps: assert property ( // see [R12]
    @(posedge hclk) disable iff (!hresetn)
    code_status_reg[4] && !hw_standby |=> code_status_reg[4])
    else $error("error flag lost");
  a_req_release: assert property ( // see [R18]
    @(posedge hclk) disable iff (!hresetn)
    state_reg == frsl_pkg::st_program |-> request_port_line)
    else $error("request held in program");
  a_done_quiet: assert property ( // see [R19]
    @(posedge hclk) disable iff (!hresetn)
    state_reg == frsl_pkg::st_done |-> request_port_line)
    else $error("request after last block");
  // A wide write to the status must leave the download bit alone
  a_byte_only: assert property ( // see [R10]
    @(posedge hclk) disable iff (!hresetn)
    req_reg.htrans_nonseq && req_reg.hwrite && req_reg.hsize != 3'h0 &&
    req_reg.addr == frsl_pkg::ofs_code_status && !stby_init &&
    state_reg != frsl_pkg::st_erase |=> $stable(code_status_reg[0]))
    else $error("wide write accepted");
endmodule // frsl_top
`default_nettype wire

// File: shared/frsl_pkg.sv
// Package: constants and types for the flash reprogram serial loader
package frsl_pkg;
  // Register byte offsets
  localparam logic [7:0] ofs_code_status = 8'h00;
  localparam logic [7:0] ofs_sys_ctrl2 = 8'h04;
  localparam logic [7:0] ofs_control = 8'h08;
  localparam logic [7:0] ofs_irq_status = 8'h0c;
  localparam logic [7:0] ofs_irq_mask = 8'h10;
  localparam logic [7:0] ofs_ram_emul = 8'h14;
  localparam logic [7:0] ofs_start_addr = 8'h18;
  localparam logic [7:0] ofs_timer_lo = 8'h1c;
  localparam logic [7:0] ofs_timer_hi = 8'h20;
  // Field positions
  localparam int code_status_rsv7_bit = 7;
  localparam int code_status_err_bit = 4;
  localparam int code_status_dl_bit = 0;
  localparam int sys_ctrl2_flash_en_bit = 3;
  // Reset value and write mask
  localparam logic [7:0] code_status_reset = 8'h80;
  localparam logic [7:0] code_status_wmask = 8'h01;
  // Flash geometry
  localparam int unit_bytes = 128;
  localparam int num_blocks = 3;
  localparam int erase_cycles = 64;
  localparam int prog_cycles = 16;
  localparam logic [7:0] block_bytes = 8'hff;
  // Link: 1 Mbps from a 100 MHz clock
  localparam int clk_mhz = 100;
  localparam int bit_rate_mbps = 1;
  localparam int bit_cycles = clk_mhz / bit_rate_mbps;
  // Interrupt status bits
  localparam int ev_erase_done = 0;
  localparam int ev_block_done = 1;
  localparam int ev_all_done = 2;
  localparam int ev_error = 3;

  typedef enum logic [2:0] {
    st_idle, st_erase, st_request, st_receive, st_program, st_done
  } frsl_state_t;

  typedef struct packed {
    logic htrans_nonseq;
    logic hwrite;
    logic [7:0] addr;
    logic [2:0] hsize;
  } frsl_req_t;
endpackage

// File: sim/frsl_tool_model.sv
// Programming tool model: answers each request with one serial frame
`timescale 1ns/1ps
`default_nettype none
module frsl_tool_model (
  input wire logic request_port_line,
  output logic serial_clk,
  output logic serial_data,
  output logic [3:0] req_cnt
);
  // Clock rests low outside frames, the tool only ever transmits
  initial
  begin
    serial_clk = 1'b0;
    serial_data = 1'b1;
    req_cnt = 4'h0;
  end

  // A falling edge is the send request; 256 bytes MSB first
  always @(negedge request_port_line)
  begin : frame
    logic [7:0] b;
    req_cnt = req_cnt + 4'h1;
    for (int i = 0; i < 256; i++)
    begin
      b = 8'(i) ^ 8'h5a;
      for (int k = 7; k >= 0; k--)
      begin
        serial_data = b[k];
        #40 serial_clk = 1'b1;
        #40 serial_clk = 1'b0;
      end
    end
    // Released line shows the inverse so stale data is not trusted
    serial_data = ~serial_data;
  end
endmodule // frsl_tool_model
`default_nettype wire

// File: sim/tb_flash_reprogram_serial_loader.sv
// Testbench for the flash reprogram serial loader
`timescale 1ns/1ps
`default_nettype none
module tb_flash_reprogram_serial_loader;
  typedef struct {
    logic wr;
    logic [7:0] addr;
    logic [2:0] hsz;
    logic [7:0] wdata;
    logic [7:0] exp;
  } frsl_row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic md0 = 1'b1;
  logic md1 = 1'b0;
  logic md2 = 1'b0;
  logic hw_standby = 1'b0;
  logic sw_standby = 1'b0;
  logic watch_mode = 1'b0;
  logic flash_fault = 1'b0;
  wire logic serial_clk;
  wire logic serial_data;
  logic request_port_line;
  logic irq;
  logic [3:0] req_cnt;
  logic [7:0] rd;
  int error_cnt = 0;
  int total_checks = 0;
  int n;
  frsl_row_t rows [15];

  always #5 hclk = ~hclk;

  frsl_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .mode_select_0(md0), .mode_select_1(md1),
    .mode_select_2(md2), .hw_standby(hw_standby),
    .sw_standby(sw_standby), .watch_mode(watch_mode),
    .flash_fault(flash_fault), .serial_clk(serial_clk),
    .serial_data(serial_data), .request_port_line(request_port_line),
    .irq(irq)
  );

  frsl_tool_model tool (
    .request_port_line(request_port_line), .serial_clk(serial_clk),
    .serial_data(serial_data), .req_cnt(req_cnt)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Waits on hready are bounded so a dead slave shows as a mismatch
  task automatic wait_ready();
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
      chk(1'b0, 1'b1);
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [2:0] sz, input logic [7:0] wd);
    @(posedge hclk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= sz;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_ready();
    rd = hrdata[7:0];
  endtask

  task automatic wait_line(input logic v, input int limit);
    n = 0;
    while (request_port_line !== v && n < limit)
    begin
      @(posedge hclk);
      n++;
    end
    chk(request_port_line, v);
  endtask

  task automatic standby(input logic hw);
    @(posedge hclk);
    hw_standby <= hw;
    sw_standby <= ~hw;
    repeat (2) @(posedge hclk);
    hw_standby <= 1'b0;
    sw_standby <= 1'b0;
    ahb(1'b1, frsl_pkg::ofs_sys_ctrl2, 3'h0, 8'h08);
  endtask

  // Hang guard: whole run is well under this span
  initial
  begin
    #800000;
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    rows = '{
      '{0, frsl_pkg::ofs_sys_ctrl2, 3'h0, 8'h00, 8'h00},
      '{0, frsl_pkg::ofs_code_status, 3'h0, 8'h00, 8'h00},
      '{1, frsl_pkg::ofs_timer_lo, 3'h0, 8'h5a, 8'h00},
      '{0, frsl_pkg::ofs_timer_lo, 3'h0, 8'h00, 8'h5a},
      '{1, frsl_pkg::ofs_sys_ctrl2, 3'h0, 8'h08, 8'h00},
      '{0, frsl_pkg::ofs_timer_lo, 3'h0, 8'h00, 8'h00},
      '{0, frsl_pkg::ofs_code_status, 3'h0, 8'h00, 8'h80},
      '{1, frsl_pkg::ofs_code_status, 3'h0, 8'h61, 8'h00},
      '{0, frsl_pkg::ofs_code_status, 3'h0, 8'h00, 8'h81},
      '{1, frsl_pkg::ofs_code_status, 3'h2, 8'h00, 8'h00},
      '{0, frsl_pkg::ofs_code_status, 3'h0, 8'h00, 8'h81},
      '{1, frsl_pkg::ofs_code_status, 3'h0, 8'h80, 8'h00},
      '{0, 8'h3c, 3'h0, 8'h00, 8'h00},
      '{1, frsl_pkg::ofs_irq_mask, 3'h0, 8'h0f, 8'h00},
      '{0, frsl_pkg::ofs_irq_mask, 3'h0, 8'h00, 8'h0f}
    };
    // User boot straps held 1/0/0 for the whole run
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    chk(request_port_line, 1'b1);
    foreach (rows[i])
    begin
      ahb(rows[i].wr, rows[i].addr, rows[i].hsz, rows[i].wdata);
      if (!rows[i].wr)
        chk(rd, rows[i].exp);
    end
    chk(hresp, 1'b0);
    // Full three-block load
    ahb(1'b1, frsl_pkg::ofs_control, 3'h0, 8'h01);
    for (int b = 0; b < frsl_pkg::num_blocks; b++)
    begin
      wait_line(1'b0, 2000);
      if (b == 0)
        chk(n >= 3 * frsl_pkg::erase_cycles, 1'b1);
      // Not busy while receiving, so the unmasked events show
      chk(irq, 1'b1);
      wait_line(1'b1, 30000);
      // Program runs now; the level drops one edge after it starts
      repeat (2) @(posedge hclk);
      chk(irq, 1'b0);
    end
    repeat (3000) @(posedge hclk);
    chk(req_cnt, 4'h3);
    chk(irq, 1'b1);
    ahb(1'b0, frsl_pkg::ofs_irq_status, 3'h0, 8'h00);
    chk(rd, 8'h07);
    // Clear lands at the data phase edge, the level one edge later
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    // Standby wipes the mask; a fault sets the error monitor
    standby(1'b0);
    ahb(1'b0, frsl_pkg::ofs_irq_mask, 3'h0, 8'h00);
    chk(rd, 8'h00);
    flash_fault <= 1'b1;
    // First start leaves the done state, the second starts an erase
    ahb(1'b1, frsl_pkg::ofs_control, 3'h0, 8'h01);
    ahb(1'b1, frsl_pkg::ofs_control, 3'h0, 8'h01);
    repeat (300) @(posedge hclk);
    flash_fault <= 1'b0;
    ahb(1'b0, frsl_pkg::ofs_code_status, 3'h0, 8'h00);
    chk(rd, 8'h90);
    standby(1'b0);
    ahb(1'b0, frsl_pkg::ofs_code_status, 3'h0, 8'h00);
    chk(rd, 8'h90);
    ahb(1'b1, frsl_pkg::ofs_control, 3'h0, 8'h01);
    repeat (1000) @(posedge hclk);
    chk(req_cnt, 4'h3);
    standby(1'b1);
    ahb(1'b0, frsl_pkg::ofs_code_status, 3'h0, 8'h00);
    chk(rd, 8'h80);
    wrap_up();
  end
endmodule // tb_flash_reprogram_serial_loader
`default_nettype wire
